// ===== verilog/adc_cfg_pkg.sv
package adc_cfg_pkg;

    // Register indices; the bus byte address is four times the index
    localparam logic [7:0] IDX_RATE_CFG  = 8'h04;
    localparam logic [7:0] IDX_REF_CTRL  = 8'h05;
    localparam logic [7:0] IDX_CONV_CTRL = 8'h10;
    localparam logic [7:0] IDX_CONV_STAT = 8'h11;
    localparam logic [7:0] IDX_RESULT    = 8'h12;
    localparam logic [1:0] WORD_LANE     = 2'h0;

    // Reset values
    localparam logic [7:0] RATE_CFG_RESET = 8'h14;
    localparam logic [7:0] REF_CTRL_RESET = 8'h10;

    // Conversion rate register fields
    localparam int CHOP_BIT   = 7;
    localparam int CLKSEL_BIT = 6;
    localparam int MODE_BIT   = 5;
    localparam int FILTER_BIT = 4;
    localparam int RATE_LSB   = 0;
    localparam int RATE_W     = 4;

    // Reference control register fields
    localparam int MON_LSB   = 6;
    localparam int PBYP_BIT  = 5;
    localparam int NBYP_BIT  = 4;
    localparam int RSEL_LSB  = 2;
    localparam int RCON_LSB  = 0;
    localparam int FIELD2_W  = 2;

    // Own registers: start strobe and status bits
    localparam int START_BIT  = 0;
    localparam int BUSY_BIT   = 0;
    localparam int READY_BIT  = 1;
    localparam int SWAP_BIT   = 2;
    localparam int HALF_BIT   = 3;

    // Two-bit field encodings and the four-bit reserved rate code
    localparam logic [1:0] MON_OFF    = 2'h0;
    localparam logic [1:0] MON_LOW    = 2'h1;
    localparam logic [1:0] MON_THIRD  = 2'h2;
    localparam logic [1:0] MON_PULL   = 2'h3;
    localparam logic [1:0] RSEL_EXT0  = 2'h0;
    localparam logic [1:0] RSEL_EXT1  = 2'h1;
    localparam logic [1:0] RSEL_INT   = 2'h2;
    localparam logic [1:0] RCON_OFF   = 2'h0;
    localparam logic [1:0] RCON_ON_PD = 2'h1;
    localparam logic [1:0] RCON_ON    = 2'h2;
    localparam logic [3:0] RATE_RSVD  = 4'hf;

    // Oscillator tick synthesis from the 100 MHz reference
    localparam longint REF_CLK_HZ = 100_000_000;
    localparam longint OSC_HZ     = 4_096_000;
    localparam int     ACC_W      = 16;
    localparam logic [ACC_W-1:0] PHASE_INC =
        ACC_W'((OSC_HZ << ACC_W) / REF_CLK_HZ);

    localparam int PERIOD_W = 24;

    // Oscillator ticks per output sample for each rate code
    function automatic logic [PERIOD_W-1:0] rate_period(input logic [3:0] code);
        unique case (code)
            4'h0:    rate_period = 24'h190000;  // 2.5 per second
            4'h1:    rate_period = 24'h0c8000;  // 5
            4'h2:    rate_period = 24'h064000;  // 10
            4'h3:    rate_period = 24'h03c3db;  // 16.6
            4'h4:    rate_period = 24'h032000;  // 20
            4'h5:    rate_period = 24'h014000;  // 50
            4'h6:    rate_period = 24'h010aab;  // 60
            4'h7:    rate_period = 24'h00a000;  // 100
            4'h8:    rate_period = 24'h005000;  // 200
            4'h9:    rate_period = 24'h002800;  // 400
            4'ha:    rate_period = 24'h001400;  // 800
            4'hb:    rate_period = 24'h001000;  // 1000
            4'hc:    rate_period = 24'h000800;  // 2000
            default: rate_period = 24'h000400;  // 4000, reserved code unused
        endcase
    endfunction

endpackage

// ===== verilog/pacer_if.sv
`timescale 1ns/10ps
// Configuration toward the conversion pacer and its answers
interface pacer_if;
    logic       ext_sel;      // External clock ticks pace conversions
    logic [3:0] rate_code;    // Output data rate code
    logic       single_shot;  // One conversion per start
    logic       start_req;    // One-cycle start pulse
    logic       restart;      // Rate or mode rewritten
    logic       conv_start;   // One-cycle conversion start
    logic       busy;         // Pacer counting

    modport ctrl  (output ext_sel, rate_code, single_shot, start_req, restart,
                   input  conv_start, busy);
    modport pacer (input  ext_sel, rate_code, single_shot, start_req, restart,
                   output conv_start, busy);
endinterface

// ===== verilog/conv_pacer.sv
`timescale 1ns/10ps
module conv_pacer import adc_cfg_pkg::*; #(
    parameter int RATE_DIV = 1
) (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic ext_tick,
    pacer_if.pacer    pif
);

    typedef enum logic {PACE_IDLE, PACE_RUN} pace_state_type;

    pace_state_type       state_q;     // Pacer state
    logic [ACC_W-1:0]     acc_q;       // Phase accumulator
    logic                 tick_q;      // Selected clock tick
    logic [PERIOD_W-1:0]  count_q;     // Ticks left in this period
    logic                 start_q;     // Conversion start pulse
    logic [ACC_W:0]       acc_sum;     // Accumulator plus carry
    logic [PERIOD_W-1:0]  period;      // Scaled period

    assign acc_sum = {1'b0, acc_q} + {1'b0, PHASE_INC};
    // Scaling lets a simulation shorten the long periods
    assign period  = PERIOD_W'(rate_period(pif.rate_code) / RATE_DIV);

    // Tick source: on-chip oscillator by default, external ticks when chosen
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            acc_q  <= '0;
            tick_q <= 1'b0;
        end else if (ce) begin
            acc_q  <= acc_sum[ACC_W-1:0];
            tick_q <= pif.ext_sel ? ext_tick : acc_sum[ACC_W];
        end
    end

    // Period counting; a reserved rate code never starts a conversion
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= PACE_IDLE;
            count_q <= '0;
            start_q <= 1'b0;
        end else if (ce) begin
            start_q <= 1'b0;
            if (pif.rate_code == RATE_RSVD) begin
                state_q <= PACE_IDLE;
            end else if (pif.restart) begin
                // Back-to-back when continuous, else wait for a start
                state_q <= pif.single_shot ? PACE_IDLE : PACE_RUN;
                count_q <= period;
            end else begin
                unique case (state_q)
                    PACE_IDLE: begin
                        if (pif.start_req || !pif.single_shot) begin
                            state_q <= PACE_RUN;
                            count_q <= period;
                        end
                    end
                    PACE_RUN: begin
                        if (tick_q && count_q <= PERIOD_W'(1)) begin
                            start_q <= 1'b1;
                            count_q <= period;
                            if (pif.single_shot) begin
                                state_q <= PACE_IDLE;
                            end
                        end else if (tick_q) begin
                            count_q <= count_q - PERIOD_W'(1);
                        end
                    end
                endcase
            end
        end
    end

    assign pif.conv_start = start_q;
    assign pif.busy       = (state_q == PACE_RUN);

    a_idle_no_start: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ce && state_q == PACE_IDLE) |=> !start_q)
        else $error("conversion started from idle");

    a_rsvd_rate: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ce && pif.rate_code == RATE_RSVD) |=> ##1 !start_q)
        else $error("reserved rate produced a conversion");

    a_ext_tick_only: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ce && pif.ext_sel && !ext_tick) |=> !tick_q)
        else $error("tick without external clock edge");

endmodule  // conv_pacer

// ===== verilog/adc_rate_reference_config.sv
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
// What this block does
// - Global chop swaps inputs, averages reading pairs
// - Clock bit: oscillator when clear, external set
// - Mode bit: continuous when clear, single-shot set
// - Filter bit: sinc3 clear, low-latency set, resets set
// - Rate code paces output; top code reserved
// - Monitor field enables low, third, pull-together
// - Positive buffer bypass bit, reset clear
// - Negative buffer bypass bit, reset set
// - Reference select: pair0, pair1, internal, reserved
// - Internal reference off, on-until-powerdown, always on
// - Reference control at index 05h, reset 10h
// - Rate configuration at index 04h, reset 14h
module adc_rate_reference_config import adc_cfg_pkg::*; #(
    parameter int ADDR_W   = 10,
    parameter int SAMPLE_W = 16,
    parameter int RATE_DIV = 1
) (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic                ce,
    input  wire logic [ADDR_W-1:0]   address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    input  wire logic [3:0]          byteenable,
    output      logic [31:0]         readdata,
    output      logic                waitrequest,
    input  wire logic                ext_clk_tick,
    input  wire logic [SAMPLE_W-1:0] sample_data,
    input  wire logic                sample_valid,
    input  wire logic                power_down,
    output      logic                chop_en,
    output      logic                ext_clk_sel,
    output      logic                single_shot_mode,
    output      logic                low_latency_filter,
    output      logic [3:0]          rate_code,
    output      logic                conv_start,
    output      logic                chop_swap,
    output      logic [SAMPLE_W-1:0] result_data,
    output      logic                result_valid,
    output      logic                ref_low_threshold_flag_en,
    output      logic                ref_third_span_flag_en,
    output      logic                ref_pull_together_en,
    output      logic                pos_ref_buffer_bypass,
    output      logic                neg_ref_buffer_bypass,
    output      logic                ref_sel_pair0,
    output      logic                ref_sel_pair1,
    output      logic                ref_sel_internal,
    output      logic                internal_ref_on
);

    // Register word decode used by both the write and read paths
    function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                  input logic [7:0]        idx);
        hits = (addr[1:0] == WORD_LANE) &&
               (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    pacer_if pif ();

    logic [7:0]          rate_cfg_q;    // Conversion rate configuration
    logic [7:0]          ref_ctrl_q;    // Reference control
    logic                waitreq_q;     // Avalon wait request
    logic [31:0]         rdata_q;       // Avalon read data
    logic                start_req_q;   // Single-shot start pulse
    logic                restart_q;     // Rate register rewritten
    logic                swap_q;        // Input polarity swapped
    logic                half_q;        // First of a chop pair held
    logic [SAMPLE_W-1:0] held_q;        // First reading of a pair
    logic [SAMPLE_W-1:0] result_q;      // Latest output reading
    logic                result_vld_q;  // New result pulse
    logic                ready_q;       // Unread result flag
    logic                mon_low_q;     // Low-reference flag enable
    logic                mon_third_q;   // Third-span flag enable
    logic                mon_pull_q;    // Pull-together enable
    logic                sel_p0_q;      // External pair zero routed
    logic                sel_p1_q;      // External pair one routed
    logic                sel_int_q;     // Internal reference routed
    logic                int_on_q;      // Internal reference powered
    logic                wr_done;       // Write with lane zero enabled completes this edge
    logic                rd_done;       // Read completes this edge
    logic [SAMPLE_W:0]   pair_sum;      // Sum of a chop pair
    logic [31:0]         rd_mux;        // Read data selection
    logic [1:0]          mon_cfg;       // Monitor field
    logic [1:0]          rsel_cfg;      // Reference select field
    logic [1:0]          rcon_cfg;      // Internal reference field

    // A request completes at the edge that sees wait request low
    assign wr_done = write && !waitreq_q && byteenable[0];
    assign rd_done = read && !waitreq_q;

    assign mon_cfg  = ref_ctrl_q[MON_LSB  +: FIELD2_W];
    assign rsel_cfg = ref_ctrl_q[RSEL_LSB +: FIELD2_W];
    assign rcon_cfg = ref_ctrl_q[RCON_LSB +: FIELD2_W];

    // Mean of a swapped pair; sign extension keeps the sum exact
    assign pair_sum = {held_q[SAMPLE_W-1], held_q} +
                      {sample_data[SAMPLE_W-1], sample_data};

    // Read data; unmapped words read as zero
    always_comb begin
        rd_mux = '0;
        if (hits(address, IDX_RATE_CFG)) begin
            rd_mux[7:0] = rate_cfg_q;
        end else if (hits(address, IDX_REF_CTRL)) begin
            rd_mux[7:0] = ref_ctrl_q;
        end else if (hits(address, IDX_CONV_STAT)) begin
            rd_mux[BUSY_BIT]  = pif.busy;
            rd_mux[READY_BIT] = ready_q;
            rd_mux[SWAP_BIT]  = swap_q;
            rd_mux[HALF_BIT]  = half_q;
        end else if (hits(address, IDX_RESULT)) begin
            rd_mux[SAMPLE_W-1:0] = result_q;
        end
    end

    // Every request waits exactly one cycle; data is ready with the answer
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            waitreq_q <= 1'b1;
            rdata_q   <= '0;
        end else if (ce) begin
            if ((read || write) && waitreq_q) begin
                waitreq_q <= 1'b0;
                rdata_q   <= read ? rd_mux : '0;
            end else begin
                waitreq_q <= 1'b1;
            end
        end
    end

    // Rate configuration register; reset selects low latency at 20 per second
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rate_cfg_q <= RATE_CFG_RESET;
        end else if (ce && wr_done && hits(address, IDX_RATE_CFG)) begin
            rate_cfg_q <= writedata[7:0];
        end
    end

    // Reference control register; reset leaves only the negative bypass set
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ref_ctrl_q <= REF_CTRL_RESET;
        end else if (ce && wr_done && hits(address, IDX_REF_CTRL)) begin
            ref_ctrl_q <= writedata[7:0];
        end
    end

    // Start and restart strobes toward the pacer
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            start_req_q <= 1'b0;
            restart_q   <= 1'b0;
        end else if (ce) begin
            start_req_q <= wr_done && hits(address, IDX_CONV_CTRL) &&
                           writedata[START_BIT];
            // Rewriting rate or mode throws away the period in progress
            restart_q   <= wr_done && hits(address, IDX_RATE_CFG);
        end
    end

    // Pacer configuration straight from the register fields, start and restart strobes from their flip-flops
    assign pif.ext_sel     = rate_cfg_q[CLKSEL_BIT];
    assign pif.single_shot = rate_cfg_q[MODE_BIT];
    assign pif.rate_code   = rate_cfg_q[RATE_LSB +: RATE_W];
    assign pif.start_req   = start_req_q;
    assign pif.restart     = restart_q;

    conv_pacer #(
        .RATE_DIV (RATE_DIV)
    ) u_pacer (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .ce       (ce),
        .ext_tick (ext_clk_tick),
        .pif      (pif.pacer)
    );

    // Chop pairing: polarity flips per reading, output is the pair mean
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            swap_q <= 1'b0;
            half_q <= 1'b0;
            held_q <= '0;
        end else if (ce) begin
            if (!rate_cfg_q[CHOP_BIT] || restart_q) begin
                // Disabled or reconfigured: start a fresh pair unswapped
                swap_q <= 1'b0;
                half_q <= 1'b0;
            end else if (sample_valid) begin
                swap_q <= !swap_q;
                half_q <= !half_q;
                if (!half_q) begin
                    held_q <= sample_data;
                end
            end
        end
    end

    // Result path; without chop every reading passes straight through
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            result_q     <= '0;
            result_vld_q <= 1'b0;
        end else if (ce) begin
            result_vld_q <= 1'b0;
            if (sample_valid && !rate_cfg_q[CHOP_BIT]) begin
                result_q     <= sample_data;
                result_vld_q <= 1'b1;
            end else if (sample_valid && half_q && !restart_q) begin
                result_q     <= pair_sum[SAMPLE_W:1];
                result_vld_q <= 1'b1;
            end
        end
    end

    // Unread flag: a new result in the clearing cycle keeps it set
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ready_q <= 1'b0;
        end else if (ce) begin
            if (result_vld_q) begin
                ready_q <= 1'b1;
            end else if (rd_done && hits(address, IDX_RESULT)) begin
                ready_q <= 1'b0;
            end
        end
    end

    // Reference monitor enables decoded from the monitor field
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mon_low_q   <= 1'b0;
            mon_third_q <= 1'b0;
            mon_pull_q  <= 1'b0;
        end else if (ce) begin
            mon_low_q   <= (mon_cfg != MON_OFF);
            mon_third_q <= (mon_cfg == MON_THIRD);
            mon_pull_q  <= (mon_cfg == MON_PULL);
        end
    end

    // Reference routing; the reserved code connects nothing
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sel_p0_q  <= 1'b1;
            sel_p1_q  <= 1'b0;
            sel_int_q <= 1'b0;
        end else if (ce) begin
            sel_p0_q  <= (rsel_cfg == RSEL_EXT0);
            sel_p1_q  <= (rsel_cfg == RSEL_EXT1);
            sel_int_q <= (rsel_cfg == RSEL_INT);
        end
    end

    // Internal reference power; the reserved code keeps it off
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            int_on_q <= 1'b0;
        end else if (ce) begin
            int_on_q <= (rcon_cfg == RCON_ON) ||
                        (rcon_cfg == RCON_ON_PD && !power_down);
        end
    end

    // Outputs, each taken from a flip-flop
    assign readdata                  = rdata_q;
    assign waitrequest               = waitreq_q;
    assign chop_en                   = rate_cfg_q[CHOP_BIT];
    assign ext_clk_sel               = rate_cfg_q[CLKSEL_BIT];
    assign single_shot_mode          = rate_cfg_q[MODE_BIT];
    assign low_latency_filter        = rate_cfg_q[FILTER_BIT];
    assign rate_code                 = rate_cfg_q[RATE_LSB +: RATE_W];
    assign conv_start                = pif.conv_start;
    assign chop_swap                 = swap_q;
    assign result_data               = result_q;
    assign result_valid              = result_vld_q;
    assign ref_low_threshold_flag_en = mon_low_q;
    assign ref_third_span_flag_en    = mon_third_q;
    assign ref_pull_together_en      = mon_pull_q;
    assign pos_ref_buffer_bypass     = ref_ctrl_q[PBYP_BIT];
    assign neg_ref_buffer_bypass     = ref_ctrl_q[NBYP_BIT];
    assign ref_sel_pair0             = sel_p0_q;
    assign ref_sel_pair1             = sel_p1_q;
    assign ref_sel_internal          = sel_int_q;
    assign internal_ref_on           = int_on_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_rate_reset: assert property ($rose(resetn) |-> rate_cfg_q == RATE_CFG_RESET)
        else $error("rate register reset value wrong");

    a_ref_reset: assert property ($rose(resetn) |-> ref_ctrl_q == REF_CTRL_RESET)
        else $error("reference register reset value wrong");

    a_ref_write: assert property (
        (ce && wr_done && hits(address, IDX_REF_CTRL))
        |=> ref_ctrl_q == $past(writedata[7:0]))
        else $error("reference register write lost");

    a_chop_mean: assert property (
        (ce && chop_en && !restart_q && sample_valid && half_q)
        |=> result_valid && result_data ==
            SAMPLE_W'(($past(pair_sum)) >> 1))
        else $error("chop pair mean missing");

    a_chop_first: assert property (
        (ce && chop_en && !restart_q && sample_valid && !half_q)
        |=> !result_valid && half_q && chop_swap != $past(chop_swap))
        else $error("first chop reading mishandled");

    a_mon_third: assert property (
        (ce && mon_cfg == MON_THIRD) |=> mon_low_q && mon_third_q && !mon_pull_q)
        else $error("third-span monitor decode wrong");

    a_rsel_rsvd: assert property (
        (ce && rsel_cfg == 2'h3) |=> !(sel_p0_q || sel_p1_q || sel_int_q))
        else $error("reserved reference select routed");

    a_int_pd_off: assert property (
        (ce && rcon_cfg == RCON_ON_PD && power_down) |=> !int_on_q)
        else $error("internal reference stayed on in power-down");

    a_bus_answer: assert property (
        (ce && (read || write) && waitreq_q) |=> !waitrequest)
        else $error("bus answer late");

endmodule  // adc_rate_reference_config

// ===== verif/adc_rate_reference_config_tb.sv
`timescale 1ns/10ps
module adc_rate_reference_config_tb import adc_cfg_pkg::*; ;
    logic        ref_clk, resetn, ce, read, write, waitrequest, ext_clk_tick, sample_valid;
    logic        power_down, chop_en, ext_clk_sel, single_shot_mode, low_latency_filter;
    logic        conv_start, chop_swap, result_valid, lo_en, th_en, pt_en, pb, nb, p0, p1;
    logic        ri, ir_on;            // Reference routing and power outputs
    logic [9:0]  address;              // Byte address, index times four
    logic [31:0] writedata, readdata, q;
    logic [3:0]  byteenable, be, rate_code;
    logic [15:0] sample_data, result_data;
    int          miscompares, checked, nstart, nres;
    adc_rate_reference_config #(.RATE_DIV(4096)) uut (.ref_clk(ref_clk), .resetn(resetn),
        .ce(ce), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .ext_clk_tick(ext_clk_tick), .sample_data(sample_data), .sample_valid(sample_valid),
        .power_down(power_down), .chop_en(chop_en), .ext_clk_sel(ext_clk_sel),
        .single_shot_mode(single_shot_mode), .low_latency_filter(low_latency_filter),
        .rate_code(rate_code), .conv_start(conv_start), .chop_swap(chop_swap),
        .result_data(result_data), .result_valid(result_valid),
        .ref_low_threshold_flag_en(lo_en), .ref_third_span_flag_en(th_en),
        .ref_pull_together_en(pt_en), .pos_ref_buffer_bypass(pb), .neg_ref_buffer_bypass(nb),
        .ref_sel_pair0(p0), .ref_sel_pair1(p1), .ref_sel_internal(ri), .internal_ref_on(ir_on));
    // Free-running 100 MHz clock
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Pulse counters; results compared after their pulses settle, starts after a fixed window
    always @(posedge ref_clk) begin
        if (conv_start === 1'b1) nstart <= nstart + 1;
        if (result_valid === 1'b1) nres <= nres + 1;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One Avalon transfer; request held until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= {24'h0, d};
        byteenable <= be;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 0;
        write <= 0;
    endtask
    task smp(input logic [15:0] d);
        @(posedge ref_clk);
        sample_valid <= 1;
        sample_data <= d;
    endtask
    // Count conversion starts after a rate write, optionally with one start strobe
    task pace(input logic [7:0] d, input logic st, input int exp_min, input int exp_max);
        bus(1, IDX_RATE_CFG, d);
        if (st) bus(1, IDX_CONV_CTRL, 8'h01);
        nstart = 0;
        repeat (600) @(posedge ref_clk);
        check(nstart >= exp_min && nstart <= exp_max, 1);
    endtask
    task t_reset;
        bus(0, IDX_RATE_CFG, 0); check(q, 32'h14);
        bus(0, IDX_REF_CTRL, 0); check(q, 32'h10);
        check({nb, p0, ir_on, low_latency_filter, rate_code}, 8'hd4);
        $display("t_reset done");
    endtask
    // Every code of each reference field, power-down both ways
    task t_ref;
        logic [1:0] k;
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            bus(1, IDX_REF_CTRL, {k, k[0], k[1], k, k});
            bus(0, IDX_REF_CTRL, 0); check(q, {24'h0, k, k[0], k[1], k, k});
            check({lo_en, th_en, pt_en, pb, nb, p0, p1, ri},
                  {k != 0, k == 2, k == 3, k[0], k[1], k == 0, k == 1, k == 2});
            check(ir_on, k == 1 || k == 2);
            power_down <= 1;
            repeat (3) @(posedge ref_clk);
            check(ir_on, k == 2);
            power_down <= 0;
        end
        be = 4'h0; // Lane zero disabled: write ignored
        bus(1, IDX_REF_CTRL, 8'h00); bus(0, IDX_REF_CTRL, 0); check(q, 32'hff);
        be = 4'hf;
        bus(1, 8'h20, 8'hff); bus(0, 8'h20, 0); check(q, 0);
        // Internal reference in use: both bypasses set, reference kept on
        bus(1, IDX_REF_CTRL, 8'h3a);
        repeat (2) @(posedge ref_clk);
        check({pb, nb, ri, ir_on}, 4'hf);
        $display("t_ref done");
    endtask
    task t_rate;
        logic [7:0] d;
        for (int j = 0; j < 4; j++) begin
            d = (8'h10 << j) | 8'(j);
            bus(1, IDX_RATE_CFG, d);
            @(posedge ref_clk); // Field outputs change at the write edge itself
            check({chop_en, ext_clk_sel, single_shot_mode, low_latency_filter, rate_code}, d);
        end
        pace(8'h2a, 1, 1, 1);
        pace(8'h0a, 0, 5, 40);
        pace(8'h2f, 1, 0, 0);
        ext_clk_tick <= 1; // External tick every cycle paces one start per cycle
        pace(8'h4a, 0, 500, 600);
        ext_clk_tick <= 0;
        pace(8'h4a, 0, 0, 0);
        $display("t_rate done");
    endtask
    // Chop pairs average signed readings; plain mode passes each reading
    task t_chop;
        bus(1, IDX_RATE_CFG, 8'h8a);
        nres = 0;
        smp(16'h0010); smp(16'h0030); @(posedge ref_clk) sample_valid <= 0;
        repeat (3) @(posedge ref_clk);
        check({nres[7:0], result_data}, 24'h010020);
        smp(16'h8000); smp(16'hfffe); @(posedge ref_clk) sample_valid <= 0;
        repeat (3) @(posedge ref_clk);
        check({nres[7:0], result_data}, 24'h02bfff);
        // A lone first reading swaps polarity but gives no result
        smp(16'h0001);
        @(posedge ref_clk) sample_valid <= 0;
        @(posedge ref_clk);
        check({chop_swap, nres[7:0]}, 9'h102);
        bus(1, IDX_RATE_CFG, 8'h0a);
        smp(16'h1234); @(posedge ref_clk) sample_valid <= 0;
        repeat (3) @(posedge ref_clk);
        check({nres[7:0], result_data}, 24'h031234);
        ce <= 0; // Frozen block must ignore a reading
        smp(16'h5555);
        @(posedge ref_clk) sample_valid <= 0;
        ce <= 1;
        repeat (2) @(posedge ref_clk);
        check({nres[7:0], result_data}, 24'h031234);
        $display("t_chop done");
    endtask
    task print_verdict;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog well past the expected few thousand cycles
    initial begin
        #300000;
        miscompares++;
        print_verdict;
    end
    initial begin
        {resetn, read, write, ext_clk_tick, sample_valid, power_down} = 0;
        {address, writedata, sample_data} = 0;
        ce = 1; be = 4'hf; byteenable = 4'hf;
        repeat (12) @(posedge ref_clk);
        resetn <= 1;
        t_reset; t_ref; t_rate; t_chop;
        print_verdict;
    end
endmodule // adc_rate_reference_config_tb
